// ===== sar_ctrl_pkg.sv
// constants, register map and carrier types for the converter control block
package sar_ctrl_pkg;

    localparam int unsigned DATA_W     = 10;
    localparam int unsigned TRIG_N     = 8;
    localparam int unsigned PRESC_W    = 7;
    localparam int unsigned CNT_W      = 5;

    // register byte offsets
    localparam logic [7:0] OFS_INPUT_SELECT = 8'h00;
    localparam logic [7:0] OFS_CONTROL_A    = 8'h04;
    localparam logic [7:0] OFS_CONTROL_B    = 8'h08;
    localparam logic [7:0] OFS_RESULT_LOW   = 8'h0c;
    localparam logic [7:0] OFS_RESULT_HIGH  = 8'h10;

    // input_select_reg fields
    localparam int unsigned POS_CHANNEL     = 0;
    localparam int unsigned POS_LEFT_ALIGN  = 5;
    localparam int unsigned POS_REFERENCE   = 6;

    // conv_control_a fields
    localparam int unsigned POS_PRESCALE    = 0;
    localparam int unsigned POS_FLAG        = 4;
    localparam int unsigned POS_AUTO        = 5;
    localparam int unsigned POS_START       = 6;
    localparam int unsigned POS_ENABLE      = 7;

    // conv_control_b fields
    localparam int unsigned POS_TRIG_SEL    = 0;
    localparam int unsigned POS_GAIN        = 4;

    // reset values
    localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
    localparam logic [7:0] RST_CONTROL_B    = 8'h00;
    localparam logic [2:0] RST_PRESCALE     = 3'h0;

    // conversion lengths in converter clock cycles
    localparam logic [CNT_W-1:0] NORM_CYCLES  = 5'd13;
    localparam logic [CNT_W-1:0] FIRST_CYCLES = 5'd25;

    // trigger select code for back-to-back operation
    localparam logic [3:0] TRIG_FREE_RUN = 4'h0;

    typedef enum logic [1:0] {GAIN_5X, GAIN_10X, GAIN_20X, GAIN_40X} gain_type;

    typedef struct packed {
        logic       enable;
        logic       sample;
        logic       clk_tick;
        gain_type   gain;
        logic [1:0] reference;
        logic [3:0] channel;
    } ana_ctrl_type;

endpackage : sar_ctrl_pkg

// ===== sar_adc_conversion_control.sv
// apb-controlled conversion sequencer, result lock and trigger logic
// Function
// R1: result is ten bits, right-justified by default, left-justified when align bit set.
// R2: left-justified, the high byte alone carries the top eight bits.
// R3: reading low byte locks both result bytes; completion while locked drops result.
// R4: reading high byte releases the lock.
// R5: completion flag still sets when a locked result is dropped.
// R6: writing start bit runs one conversion; bit clears itself at completion.
// R7: channel change during conversion waits until that conversion ends.
// R8: auto-trigger enable starts conversions from source chosen by trigger select.
// R9: rising trigger edge resets prescaler and starts a conversion.
// R10: trigger still high at completion starts nothing; only new edge counts.
// R11: trigger edge during conversion is ignored and not queued.
// R12: trigger source flags set by events even with interrupts off.
// R13: software clears a trigger source flag before the next event.
// R14: completion flag as source gives back-to-back conversions after first start.
// R15: software avoids back-to-back mode on amplified differential channels.
// R16: start bit write launches one conversion even with auto-trigger on.
// R17: start bit reads one during any conversion, acting as busy.
// R18: reference selection applies whether or not converter is enabled.
// R19: software should disable converter before entering sleep.
// R20: channel field selects eleven pins, ground, bandgap and two amplified pairs.
// R21: amplifier gain selects 5x, 10x, 20x or 40x.
// R22: a normal conversion lasts thirteen converter clock cycles.
// R23: first conversion after enable lasts twenty-five converter clock cycles.
// R24: prescaler runs only while enabled, held in reset otherwise.
// R25: completion writes result, sets flag, and clears start bit together.
// R26: trigger edges found by comparing registered level with previous cycle.
// R27: reset leaves converter idle, unlocked, with zero result bytes.
`timescale 1ns/10ps
module sar_adc_conversion_control
    import sar_ctrl_pkg::*;
#(
    parameter int unsigned TRIGGERS = TRIG_N
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata_q,
    output logic                     pready_q,
    output logic                     pslverr_q,
    input  wire logic [TRIGGERS-1:0] trig_src,
    input  wire logic [DATA_W-1:0]   conv_data,
    output ana_ctrl_type             ana_ctrl_q,
    output logic                     conv_done_q
);

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic [15:0] place_result(input logic [DATA_W-1:0] v,
                                                 input logic left);
        if (left) begin
            place_result = {v, 6'h00};
        end else begin
            place_result = {6'h00, v};
        end
    endfunction : place_result

    function automatic logic [PRESC_W-1:0] presc_last(input logic [2:0] ps);
        logic [7:0] div;
        div = 8'h02 << ps;
        presc_last = div[PRESC_W-1:0] - 7'h01;
    endfunction : presc_last

    ////////////////////////////////////////////////////////////////////////
    // registers and nets

    logic [7:0]         input_select_q;
    logic [7:0]         control_b_q;
    logic [2:0]         prescale_q;
    logic               enable_q;
    logic               auto_q;
    logic               flag_q;
    logic               busy_q;
    logic               pend_q;
    logic               first_q;
    logic               lock_q;
    logic [15:0]        result_q;
    logic [PRESC_W-1:0] presc_q;
    logic [CNT_W-1:0]   cnt_q;
    logic               trig_lvl_q;
    logic               trig_prev_q;
    logic [3:0]         chan_live_q;
    logic [1:0]         gain_live_q;

    logic       setup;
    logic       access;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic       hit;
    logic       tick;
    logic       done;
    logic       free_run;
    logic       trig_sel;
    logic       trig_edge;
    logic       trig_start;
    logic       sw_start;
    logic       rd_low;
    logic       rd_high;
    logic [3:0] tsel;
    logic [CNT_W-1:0] conv_len;

    assign setup  = psel & ~penable;
    assign access = psel & penable & pready_q;
    assign wr     = access & pwrite;
    assign rd     = access & ~pwrite;
    assign addr   = paddr[7:0];
    assign hit    = (paddr[31:8] == 24'h000000) && (addr == OFS_INPUT_SELECT || addr == OFS_CONTROL_A
                    || addr == OFS_CONTROL_B || addr == OFS_RESULT_LOW || addr == OFS_RESULT_HIGH);
    assign rd_low  = rd & hit & (addr == OFS_RESULT_LOW);
    assign rd_high = rd & hit & (addr == OFS_RESULT_HIGH);
    assign tsel    = control_b_q[POS_TRIG_SEL +: 4];
    assign free_run = auto_q & (tsel == TRIG_FREE_RUN);
    assign sw_start = wr & hit & (addr == OFS_CONTROL_A) & pwdata[POS_START] & pwdata[POS_ENABLE];
    assign conv_len = first_q ? FIRST_CYCLES : NORM_CYCLES;

    ////////////////////////////////////////////////////////////////////////
    // apb slave, no wait state, answer registered

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            if (setup && !pwrite && hit) begin
                if (addr == OFS_INPUT_SELECT) begin
                    prdata_q <= {24'h000000, input_select_q};
                end else if (addr == OFS_CONTROL_A) begin
                    prdata_q <= {24'h000000, enable_q, busy_q | pend_q, auto_q, flag_q, 1'b0, prescale_q}; // R17
                end else if (addr == OFS_CONTROL_B) begin
                    prdata_q <= {24'h000000, control_b_q};
                end else if (addr == OFS_RESULT_LOW) begin
                    prdata_q <= {24'h000000, result_q[7:0]};
                end else begin
                    prdata_q <= {24'h000000, result_q[15:8]}; // R2
                end
            end else begin
                prdata_q <= 32'h00000000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software-written fields

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_select_q <= RST_INPUT_SELECT;
            control_b_q    <= RST_CONTROL_B;
            prescale_q     <= RST_PRESCALE;
            enable_q       <= 1'b0;
            auto_q         <= 1'b0;
        end else if (wr && hit) begin
            if (addr == OFS_INPUT_SELECT) begin
                input_select_q <= pwdata[7:0];
            end else if (addr == OFS_CONTROL_A) begin
                prescale_q <= pwdata[POS_PRESCALE +: 3];
                enable_q   <= pwdata[POS_ENABLE];
                auto_q     <= pwdata[POS_AUTO]; // R8
            end else if (addr == OFS_CONTROL_B) begin
                control_b_q <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler

    // compare at or above the end so a smaller divide never lets the count wrap
    assign tick = enable_q & (presc_q >= presc_last(prescale_q));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_q <= '0;
        end else if (!enable_q || trig_start || tick) begin
            presc_q <= '0; // R24 R9
        end else begin
            presc_q <= presc_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // trigger edge detection

    assign trig_sel   = (tsel == TRIG_FREE_RUN) ? 1'b0 : trig_src[tsel[2:0]]; // R12
    assign trig_edge  = trig_lvl_q & ~trig_prev_q; // R26
    assign trig_start = enable_q & auto_q & ~free_run & trig_edge & ~busy_q & ~pend_q; // R9 R10 R11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_lvl_q  <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            trig_lvl_q  <= trig_sel;
            trig_prev_q <= trig_lvl_q; // R26
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencer

    assign done = busy_q & tick & (cnt_q == conv_len - 5'd1); // R22 R23

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
        end else if (sw_start && !busy_q && !pend_q && !trig_start) begin
            // start may come in the same write that sets the enable
            pend_q <= 1'b1; // R6 R16
        end else if (!enable_q || (pend_q && tick)) begin
            pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0; // R27
            cnt_q  <= '0;
        end else if (!enable_q) begin
            busy_q <= 1'b0;
            cnt_q  <= '0;
        end else if (trig_start || (pend_q && tick)) begin
            busy_q <= 1'b1;
            cnt_q  <= '0;
        end else if (done) begin
            busy_q <= free_run; // R6 R14 R25
            cnt_q  <= '0;
        end else if (busy_q && tick) begin
            cnt_q <= cnt_q + 5'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_q <= 1'b1;
        end else if (!enable_q) begin
            first_q <= 1'b1;
        end else if (done) begin
            first_q <= 1'b0; // R23
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // completion flag, set wins over write-one-clear

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= 1'b0;
        end else if (done) begin
            flag_q <= 1'b1; // R5 R25
        end else if (wr && hit && addr == OFS_CONTROL_A && pwdata[POS_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result bytes and read lock

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0; // R27
        end else if (rd_high) begin
            lock_q <= 1'b0; // R4
        end else if (rd_low) begin
            lock_q <= 1'b1; // R3
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_q <= 16'h0000; // R27
        end else if (done && !lock_q) begin
            result_q <= place_result(conv_data, input_select_q[POS_LEFT_ALIGN]); // R1 R3 R25
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // analog-side controls

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_live_q <= 4'h0;
            gain_live_q <= 2'h0;
        end else if (!busy_q || done) begin
            chan_live_q <= input_select_q[POS_CHANNEL +: 4]; // R7 R20
            gain_live_q <= control_b_q[POS_GAIN +: 2]; // R21
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ana_ctrl_q  <= '0;
            conv_done_q <= 1'b0;
        end else begin
            ana_ctrl_q.enable    <= enable_q;
            ana_ctrl_q.sample    <= trig_start | (pend_q & tick) | (done & free_run);
            ana_ctrl_q.clk_tick  <= tick;
            ana_ctrl_q.gain      <= gain_type'(gain_live_q); // R21
            ana_ctrl_q.reference <= input_select_q[POS_REFERENCE +: 2]; // R18
            ana_ctrl_q.channel   <= chan_live_q; // R20
            conv_done_q          <= done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions

    sequence s_low_read;
        rd_low ##1 lock_q;
    endsequence

    sequence s_high_read;
        rd_high ##1 !lock_q;
    endsequence

    a_lock_blocks_update: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (done && lock_q) |=> $stable(result_q))
        else $error("result changed while locked");

    a_lock_sets_low: assert property (@(posedge pclk) disable iff (!presetn) // R3
        (rd_low && !rd_high) |-> s_low_read)
        else $error("low byte read did not lock");

    a_unlock_high_read: assert property (@(posedge pclk) disable iff (!presetn) // R4
        rd_high |-> s_high_read)
        else $error("high byte read did not unlock");

    a_flag_on_done: assert property (@(posedge pclk) disable iff (!presetn) // R5
        done |=> flag_q)
        else $error("flag not set at completion");

    a_single_clears: assert property (@(posedge pclk) disable iff (!presetn) // R6
        (done && !free_run && !trig_start) |=> !busy_q)
        else $error("single conversion left busy");

    a_free_run_keeps: assert property (@(posedge pclk) disable iff (!presetn) // R14
        (done && free_run && enable_q) |=> busy_q && cnt_q == 5'd0)
        else $error("free run did not restart");

    a_channel_frozen: assert property (@(posedge pclk) disable iff (!presetn) // R7
        (busy_q && $past(busy_q) && !$past(done)) |-> $stable(chan_live_q))
        else $error("channel changed mid conversion");

    a_trig_starts: assert property (@(posedge pclk) disable iff (!presetn) // R9
        trig_start |=> busy_q && presc_q == 7'h00 && cnt_q == 5'd0)
        else $error("trigger edge did not start");

    a_trig_ignored: assert property (@(posedge pclk) disable iff (!presetn) // R11
        (busy_q && trig_edge && !done) |=> !pend_q)
        else $error("edge queued during conversion");

    a_presc_held: assert property (@(posedge pclk) disable iff (!presetn) // R24
        !enable_q |=> presc_q == 7'h00 && !busy_q)
        else $error("prescaler ran while disabled");

    a_norm_length: assert property (@(posedge pclk) disable iff (!presetn) // R22
        (done && !first_q) |-> cnt_q == NORM_CYCLES - 5'd1)
        else $error("normal conversion length wrong");

    a_left_high_byte: assert property (@(posedge pclk) disable iff (!presetn) // R2
        (done && !lock_q && input_select_q[POS_LEFT_ALIGN]) |=> result_q[15:8] == $past(conv_data[9:2]))
        else $error("left aligned high byte wrong");

endmodule : sar_adc_conversion_control

// ===== sar_analog_model.sv
// analog core and trigger source model for the converter control bench
`timescale 1ns/10ps
module sar_analog_model
    import sar_ctrl_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire ana_ctrl_type ana_ctrl_q,
    input  wire logic         conv_done_q,
    input  wire logic [7:0]   trig_req,
    output logic [TRIG_N-1:0] trig_src,
    output logic [DATA_W-1:0] conv_data
);
    logic busy_q;

    ////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_q <= 1'b0;
        end else if (ana_ctrl_q.sample) begin
            busy_q <= 1'b1;
        end else if (conv_done_q) begin
            busy_q <= 1'b0;
        end
    end

    // result follows the live channel; outside a conversion the lines are inverted
    assign conv_data = busy_q ? {ana_ctrl_q.channel, 6'h2d} : ~{ana_ctrl_q.channel, 6'h2d};
    // levels come from the bench, which drops each one before the next event
    assign trig_src = trig_req;
endmodule : sar_analog_model

// ===== sar_adc_conversion_control_test.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module sar_adc_conversion_control_test;
    import sar_ctrl_pkg::*;

    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [31:0]       paddr = 32'h0;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [TRIG_N-1:0] trig_src;
    logic [DATA_W-1:0] conv_data;
    ana_ctrl_type      ana_ctrl_q;
    logic              conv_done_q;
    logic [7:0]        trig_req = 8'h0;
    logic              slverr;
    logic [31:0]       rdat;
    int                n_fail = 0;
    int                n_checks = 0;
    int                cyc = 0;
    int                t_samp = 0;
    int                last_len = 0;
    int                n_samp = 0;
    int                n_tick = 0;

    sar_adc_conversion_control sar_adc_conversion_control_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
        .pslverr_q(pslverr_q), .trig_src(trig_src), .conv_data(conv_data),
        .ana_ctrl_q(ana_ctrl_q), .conv_done_q(conv_done_q));

    sar_analog_model sar_analog_model_i (
        .pclk(pclk), .presetn(presetn), .ana_ctrl_q(ana_ctrl_q), .conv_done_q(conv_done_q),
        .trig_req(trig_req), .trig_src(trig_src), .conv_data(conv_data));

    always #4 pclk = ~pclk;

    ////////////////////////////////////////
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ana_ctrl_q.sample === 1'b1) begin
            t_samp <= cyc;
            n_samp <= n_samp + 1;
        end
        if (conv_done_q === 1'b1) last_len <= cyc - t_samp;
        if (ana_ctrl_q.clk_tick === 1'b1) n_tick <= n_tick + 1;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready_q !== 1'b1 && n < 16);
        if (n == 16) n_fail++;
        rdat = prdata_q;
        slverr = pslverr_q;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask : rdm

    task automatic wait_done();
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (conv_done_q !== 1'b1 && n < 400);
        chk(32'(n < 400), 32'd1);
        @(posedge pclk);
    endtask : wait_done

    ////////////////////////////////////////
    task automatic t_reset();
        rdm(OFS_RESULT_LOW, 32'hff, 32'h0);
        rdm(OFS_RESULT_HIGH, 32'hff, 32'h0);
        rdm(OFS_CONTROL_A, 32'h40, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk(rdat, 32'h0);
        chk({31'h0, slverr}, 32'h1);
    endtask : t_reset

    task automatic t_single();
        int first;
        apb(1'b1, OFS_INPUT_SELECT, 32'h03);
        apb(1'b1, OFS_CONTROL_A, 32'hc0);
        rdm(OFS_CONTROL_A, 32'h40, 32'h40);
        wait_done();
        first = last_len;
        rdm(OFS_CONTROL_A, 32'h50, 32'h10);
        rdm(OFS_RESULT_LOW, 32'hff, 32'hed);
        rdm(OFS_RESULT_HIGH, 32'hff, 32'h00);
        apb(1'b1, OFS_INPUT_SELECT, 32'h25);
        apb(1'b1, OFS_CONTROL_A, 32'hd0);
        wait_done();
        chk(32'(first - last_len), 32'd24);
        rdm(OFS_RESULT_HIGH, 32'hff, 32'h5b);
        rdm(OFS_RESULT_LOW, 32'hff, 32'h40);
        rdm(OFS_RESULT_HIGH, 32'hff, 32'h5b);
    endtask : t_single

    task automatic t_lock();
        apb(1'b1, OFS_INPUT_SELECT, 32'h03);
        apb(1'b1, OFS_CONTROL_A, 32'hd0);
        apb(1'b1, OFS_INPUT_SELECT, 32'h09);
        @(posedge pclk);
        chk(32'(ana_ctrl_q.channel), 32'h3);
        wait_done();
        @(posedge pclk);
        chk(32'(ana_ctrl_q.channel), 32'h9);
        rdm(OFS_RESULT_LOW, 32'hff, 32'hed);
        apb(1'b1, OFS_CONTROL_A, 32'hd0);
        wait_done();
        rdm(OFS_CONTROL_A, 32'h10, 32'h10);
        rdm(OFS_RESULT_HIGH, 32'hff, 32'h00);
        apb(1'b1, OFS_CONTROL_A, 32'hc0);
        wait_done();
        rdm(OFS_RESULT_LOW, 32'hff, 32'h6d);
        rdm(OFS_RESULT_HIGH, 32'hff, 32'h02);
    endtask : t_lock

    task automatic t_trig();
        int s;
        apb(1'b1, OFS_CONTROL_B, 32'h1);
        apb(1'b1, OFS_CONTROL_A, 32'hb0);
        for (int i = 1; i < 8; i++) begin
            apb(1'b1, OFS_CONTROL_B, 32'(i));
            s = n_samp;
            trig_req[i] <= 1'b1;
            repeat (8) @(posedge pclk);
            chk(32'(n_samp - s), 32'd1);
            rdm(OFS_CONTROL_A, 32'h40, 32'h40);
            trig_req[i] <= 1'b0;
            @(posedge pclk);
            trig_req[i] <= 1'b1;
            wait_done();
            repeat (40) @(posedge pclk);
            chk(32'(n_samp - s), 32'd1);
            trig_req[i] <= 1'b0;
        end
        s = n_samp;
        apb(1'b1, OFS_CONTROL_A, 32'hf1);
        wait_done();
        chk(32'(last_len), 32'(NORM_CYCLES) * 32'd4);
        repeat (40) @(posedge pclk);
        chk(32'(n_samp - s), 32'd1);
    endtask : t_trig

    task automatic t_free();
        int s;
        int t;
        apb(1'b1, OFS_CONTROL_B, 32'h0);
        apb(1'b1, OFS_INPUT_SELECT, 32'h02);
        s = n_samp;
        t = n_tick;
        apb(1'b1, OFS_CONTROL_A, 32'hf0);
        repeat (200) @(posedge pclk);
        chk(32'(n_samp - s >= 5), 32'd1);
        chk(32'(n_tick - t > 50), 32'd1);
        rdm(OFS_CONTROL_A, 32'h40, 32'h40);
        chk(32'(ana_ctrl_q.enable), 32'd1);
        apb(1'b1, OFS_CONTROL_A, 32'h00);
        repeat (2) @(posedge pclk);
        chk(32'(ana_ctrl_q.enable), 32'd0);
        t = n_tick;
        repeat (40) @(posedge pclk);
        chk(32'(n_tick - t), 32'd0);
    endtask : t_free

    task automatic t_fields();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, OFS_INPUT_SELECT, {24'h0, i[1:0], 2'b00, i[3:0]});
            apb(1'b1, OFS_CONTROL_B, {26'h0, i[1:0], 4'h0});
            repeat (2) @(posedge pclk);
            chk(32'(ana_ctrl_q.reference), 32'(i[1:0]));
            chk(32'(ana_ctrl_q.channel), 32'(i[3:0]));
            chk(32'(ana_ctrl_q.gain), 32'(i[1:0]));
        end
    endtask : t_fields

    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_single();
        t_lock();
        t_trig();
        t_free();
        t_fields();
        final_report();
    end
endmodule : sar_adc_conversion_control_test
